// ### hdl/flc_pkg.sv
package flc_pkg;

  // register indices; byte address is four times the index
  localparam int unsigned FLC_NUM_REGS = 20;
  localparam logic [4:0] FLC_IDX_CLKDIV = 5'h00;
  localparam logic [4:0] FLC_IDX_SEC = 5'h01;
  localparam logic [4:0] FLC_IDX_CMDIX = 5'h02;
  localparam logic [4:0] FLC_IDX_ECCIX = 5'h03;
  localparam logic [4:0] FLC_IDX_CFG = 5'h04;
  localparam logic [4:0] FLC_IDX_ERRCFG = 5'h05;
  localparam logic [4:0] FLC_IDX_STAT = 5'h06;
  localparam logic [4:0] FLC_IDX_ERRSTAT = 5'h07;
  localparam logic [4:0] FLC_IDX_PPROT = 5'h08;
  localparam logic [4:0] FLC_IDX_DPROT = 5'h09;
  localparam logic [4:0] FLC_IDX_COBHI = 5'h0a;
  localparam logic [4:0] FLC_IDX_COBLO = 5'h0b;
  localparam logic [4:0] FLC_IDX_RSVC = 5'h0c;
  localparam logic [4:0] FLC_IDX_RSVD = 5'h0d;
  localparam logic [4:0] FLC_IDX_ECCHI = 5'h0e;
  localparam logic [4:0] FLC_IDX_ECCLO = 5'h0f;
  localparam logic [4:0] FLC_IDX_OPT = 5'h10;
  localparam logic [4:0] FLC_IDX_LAST = 5'h13;

  // field layout
  localparam int unsigned FLC_LOADED_BIT = 7;
  localparam int unsigned FLC_DIV_W = 7;
  localparam int unsigned FLC_COMMAND_COMPLETE_FLAG_BIT = 7;

  // writable bit masks
  localparam logic [7:0] FLC_MASK_INDEX = 8'h07;
  localparam logic [7:0] FLC_MASK_CFG = 8'h93;
  localparam logic [7:0] FLC_MASK_ERRCFG = 8'h03;
  localparam logic [7:0] FLC_MASK_PPROT = 8'hff;
  localparam logic [7:0] FLC_MASK_DPROT = 8'h9f;

  // values after reset
  localparam logic [7:0] FLC_RST_BYTE = 8'h00;
  localparam logic [7:0] FLC_SEC_FAULT = 8'hff;
  localparam logic [6:0] FLC_RST_DIV = 7'h00;

endpackage : flc_pkg

// ### hdl/flc_core_if.sv
`timescale 1ns/1ps
`default_nettype none
interface flc_core_if;
  logic div_wr;
  logic [6:0] div_wdata;
  logic [6:0] div_value;
  logic div_loaded;
  logic timing_tick;
  logic [7:0] sec_value;
  logic [7:0] opt_value;
  logic nv_done;

  modport regs (
    output div_wr,
    output div_wdata,
    input div_value,
    input div_loaded,
    input timing_tick,
    input sec_value,
    input opt_value,
    input nv_done
  );

  modport clkdiv (
    input div_wr,
    input div_wdata,
    output div_value,
    output div_loaded,
    output timing_tick
  );

  modport secld (
    output sec_value,
    output opt_value,
    output nv_done
  );
endinterface : flc_core_if
`default_nettype wire

// ### hdl/flc_clkdiv.sv
`timescale 1ns/1ps
`default_nettype none
module flc_clkdiv
  import flc_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // core link
  flc_core_if.clkdiv core
);

  typedef struct packed {
    logic [6:0] div;
    logic loaded;
    logic [6:0] cnt;
    logic tick;
  } flc_div_state_t;

  flc_div_state_t st_r;
  flc_div_state_t st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    // only the first write after reset lands; the flag itself is never written
    if (core.div_wr && !st_r.loaded)
    begin
      st_nxt.div = core.div_wdata;
      st_nxt.loaded = 1'b1;
      st_nxt.cnt = 7'h00;
    end
    // divide by a nonzero value plus one, one tick per timing period
    else if (st_r.loaded && st_r.div != 7'h00)
    begin
      if (st_r.cnt >= st_r.div)
      begin
        st_nxt.cnt = 7'h00;
        st_nxt.tick = 1'b1;
      end
      else
      begin
        st_nxt.cnt = st_r.cnt + 7'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r <= '0;
    end
    else if (ce)
    begin
      st_r <= st_nxt;
    end
  end

  assign core.div_value = st_r.div;
  assign core.div_loaded = st_r.loaded;
  assign core.timing_tick = st_r.tick;

endmodule : flc_clkdiv
`default_nettype wire

// ### hdl/flc_secload.sv
`timescale 1ns/1ps
`default_nettype none
module flc_secload
  import flc_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // nonvolatile configuration read
  input wire logic nv_valid,
  input wire logic [7:0] nv_sec_byte,
  input wire logic [7:0] nv_opt_byte,
  input wire logic nv_dbl_fault,
  // core link
  flc_core_if.secld core
);

  typedef enum logic [0:0] {
    FLC_LD_WAIT = 1'b0,
    FLC_LD_DONE = 1'b1
  } flc_ld_state_t;

  typedef struct packed {
    flc_ld_state_t fsm;
    logic [7:0] sec;
    logic [7:0] opt;
  } flc_ld_reg_t;

  flc_ld_reg_t st_r;
  flc_ld_reg_t st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    case (st_r.fsm)
      FLC_LD_WAIT:
      begin
        // caught after reset release, once the configuration read completes
        if (nv_valid)
        begin
          st_nxt.sec = nv_dbl_fault ? FLC_SEC_FAULT : nv_sec_byte;
          st_nxt.opt = nv_opt_byte;
          st_nxt.fsm = FLC_LD_DONE;
        end
      end
      FLC_LD_DONE:
      begin
        st_nxt.fsm = FLC_LD_DONE;
      end
      default:
      begin
        st_nxt.fsm = FLC_LD_WAIT;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r <= '{fsm: FLC_LD_WAIT, sec: FLC_RST_BYTE, opt: FLC_RST_BYTE};
    end
    else if (ce)
    begin
      st_r <= st_nxt;
    end
  end

  assign core.sec_value = st_r.sec;
  assign core.opt_value = st_r.opt;
  assign core.nv_done = (st_r.fsm == FLC_LD_DONE);

endmodule : flc_secload
`default_nettype wire

// ### hdl/flc_regs.sv
`timescale 1ns/1ps
`default_nettype none
module flc_regs
  import flc_pkg::*;
(
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // command sequencer status
  input wire logic command_complete_flag,
  input wire logic [5:0] cmd_flags_in,
  input wire logic [1:0] ecc_fault_flags_in,
  input wire logic [15:0] ecc_result_in,
  // nonvolatile configuration read at reset
  input wire logic nv_valid,
  input wire logic [7:0] nv_sec_byte,
  input wire logic [7:0] nv_opt_byte,
  input wire logic nv_dbl_fault,
  // register contents to the controller
  output logic flash_timing_clock,
  output logic [7:0] security_state,
  output logic [2:0] command_word_index,
  output logic [2:0] ecc_result_index,
  output logic [7:0] controller_config,
  output logic [7:0] error_interrupt_config,
  output logic [7:0] program_array_protection,
  output logic [7:0] data_array_protection,
  output logic [15:0] command_object
);

  typedef struct packed {
    logic [2:0] cmd_ix;
    logic [2:0] ecc_ix;
    logic [7:0] cfg;
    logic [7:0] errcfg;
    logic [7:0] pprot;
    logic [7:0] dprot;
    logic [7:0] cob_hi;
    logic [7:0] cob_lo;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic tick;
    logic [7:0] sec;
  } flc_reg_state_t;

  flc_reg_state_t st_r;
  flc_reg_state_t st_nxt;

  flc_core_if core ();

  // access phase of an apb transfer, answered one cycle later
  logic access;
  logic wr_en;
  logic [4:0] idx;
  logic mapped;
  logic [7:0] wbyte;
  logic [7:0] rbyte;
  logic [7:0] stat_byte;

  assign access = psel && penable && !st_r.ready;
  assign idx = paddr[6:2];
  assign mapped = (paddr[1:0] == 2'b00) && (paddr[7] == 1'b0) && (idx <= FLC_IDX_LAST);
  assign wr_en = access && pwrite && mapped && pstrb[0];
  assign wbyte = pwdata[7:0];
  assign stat_byte = {command_complete_flag, 1'b0, cmd_flags_in};

  // divider write goes straight through, during the reset sequence too
  assign core.div_wr = ce && wr_en && (idx == FLC_IDX_CLKDIV);
  assign core.div_wdata = wbyte[FLC_DIV_W-1:0];

  flc_clkdiv u_clkdiv (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .core(core.clkdiv)
  );

  flc_secload u_secload (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .nv_valid(nv_valid),
    .nv_sec_byte(nv_sec_byte),
    .nv_opt_byte(nv_opt_byte),
    .nv_dbl_fault(nv_dbl_fault),
    .core(core.secld)
  );

  // read multiplexer
  always_comb
  begin
    rbyte = FLC_RST_BYTE;
    case (idx)
      FLC_IDX_CLKDIV:
      begin
        rbyte = {core.div_loaded, core.div_value};
      end
      FLC_IDX_SEC:
      begin
        rbyte = core.sec_value;
      end
      FLC_IDX_CMDIX:
      begin
        rbyte = {5'h00, st_r.cmd_ix};
      end
      FLC_IDX_ECCIX:
      begin
        rbyte = {5'h00, st_r.ecc_ix};
      end
      FLC_IDX_CFG:
      begin
        rbyte = st_r.cfg;
      end
      FLC_IDX_ERRCFG:
      begin
        rbyte = st_r.errcfg;
      end
      FLC_IDX_STAT:
      begin
        rbyte = stat_byte;
      end
      FLC_IDX_ERRSTAT:
      begin
        rbyte = {6'h00, ecc_fault_flags_in};
      end
      FLC_IDX_PPROT:
      begin
        rbyte = st_r.pprot;
      end
      FLC_IDX_DPROT:
      begin
        rbyte = st_r.dprot;
      end
      FLC_IDX_COBHI:
      begin
        rbyte = st_r.cob_hi;
      end
      FLC_IDX_COBLO:
      begin
        rbyte = st_r.cob_lo;
      end
      FLC_IDX_ECCHI:
      begin
        rbyte = ecc_result_in[15:8];
      end
      FLC_IDX_ECCLO:
      begin
        rbyte = ecc_result_in[7:0];
      end
      FLC_IDX_OPT:
      begin
        rbyte = core.opt_value;
      end
      default:
      begin
        // reserved words and unmapped addresses
        rbyte = FLC_RST_BYTE;
      end
    endcase
  end

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.ready = access;
    st_nxt.err = access && !mapped;
    st_nxt.tick = core.timing_tick;
    st_nxt.sec = core.sec_value;
    if (access)
    begin
      st_nxt.rdata = (!pwrite && mapped) ? {24'h00_0000, rbyte} : 32'h0000_0000;
    end
    // only writable bits change; read-only and reserved words drop writes
    if (wr_en)
    begin
      case (idx)
        FLC_IDX_CMDIX:
        begin
          st_nxt.cmd_ix = wbyte[2:0];
        end
        FLC_IDX_ECCIX:
        begin
          st_nxt.ecc_ix = wbyte[2:0];
        end
        FLC_IDX_CFG:
        begin
          st_nxt.cfg = wbyte & FLC_MASK_CFG;
        end
        FLC_IDX_ERRCFG:
        begin
          st_nxt.errcfg = wbyte & FLC_MASK_ERRCFG;
        end
        FLC_IDX_PPROT:
        begin
          st_nxt.pprot = wbyte & FLC_MASK_PPROT;
        end
        FLC_IDX_DPROT:
        begin
          st_nxt.dprot = wbyte & FLC_MASK_DPROT;
        end
        FLC_IDX_COBHI:
        begin
          st_nxt.cob_hi = wbyte;
        end
        FLC_IDX_COBLO:
        begin
          st_nxt.cob_lo = wbyte;
        end
        default:
        begin
          // security, status, results, options and reserved ignore writes
          st_nxt.cmd_ix = st_r.cmd_ix;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r <= '0;
    end
    else if (ce)
    begin
      st_r <= st_nxt;
    end
  end

  assign prdata = st_r.rdata;
  assign pready = st_r.ready;
  assign pslverr = st_r.err;
  assign flash_timing_clock = st_r.tick;
  assign security_state = st_r.sec;
  assign command_word_index = st_r.cmd_ix;
  assign ecc_result_index = st_r.ecc_ix;
  assign controller_config = st_r.cfg;
  assign error_interrupt_config = st_r.errcfg;
  assign program_array_protection = st_r.pprot;
  assign data_array_protection = st_r.dprot;
  assign command_object = {st_r.cob_hi, st_r.cob_lo};

endmodule : flc_regs
`default_nettype wire

// ### tb/flc_regs_properties.sv
`timescale 1ns/1ps
`default_nettype none
module flc_regs_props
  import flc_pkg::*;
(
  // apb side
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // controller side
  input wire logic flash_timing_clock,
  input wire logic [7:0] security_state
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic tk;
  logic ok;
  logic [4:0] ix;
  logic ld_r;
  logic sn_r;
  logic [6:0] dv_r;
  logic [7:0] cn_r;
  assign tk = psel && penable && !pready && ce;
  assign ix = paddr[6:2];
  assign ok = paddr[1:0] == 2'b00 && !paddr[7] && ix <= FLC_IDX_LAST;
  // first divider value and cycles since the last tick
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ld_r <= 1'b0;
      sn_r <= 1'b0;
      dv_r <= 7'h00;
      cn_r <= 8'h00;
    end
    else if (ce)
    begin
      if (tk && pwrite && ok && ix == FLC_IDX_CLKDIV && pstrb[0] && !ld_r)
      begin
        ld_r <= 1'b1;
        dv_r <= pwdata[6:0];
      end
      cn_r <= flash_timing_clock ? 8'h00 : cn_r + 8'h01;
      sn_r <= sn_r || flash_timing_clock;
    end
  end
  property p_answer; tk |=> pready; endproperty
  a_answer: assert property (p_answer) else $error("no answer after access");
  property p_refuse; tk && !ok |=> pslverr && prdata == 32'h0000_0000; endproperty
  a_refuse: assert property (p_refuse) else $error("bad address not refused");
  property p_accept; tk && ok |=> !pslverr; endproperty
  a_accept: assert property (p_accept) else $error("good address refused");
  property p_upper; pready |-> prdata[31:8] == 24'h00_0000; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_rsvd;
    tk && !pwrite && ok && (ix == 5'h0c || ix == 5'h0d || ix >= 5'h11) |=> prdata == 32'h0000_0000;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved reads nonzero");
  property p_divrd; tk && !pwrite && ok && ix == FLC_IDX_CLKDIV |=> prdata[7:0] == {ld_r, dv_r}; endproperty
  a_divrd: assert property (p_divrd) else $error("divider readback wrong");
  property p_tick; ce && flash_timing_clock && sn_r |-> cn_r == {1'b0, dv_r}; endproperty
  a_tick: assert property (p_tick) else $error("tick period wrong");
  property p_noload; !ld_r |-> !flash_timing_clock; endproperty
  a_noload: assert property (p_noload) else $error("tick before divider load");
  property p_sec; security_state != 8'h00 |=> $stable(security_state); endproperty
  a_sec: assert property (p_sec) else $error("security value changed");
  c_refuse: cover property (tk && !ok);
  c_tick: cover property (flash_timing_clock && sn_r);
  c_divwr: cover property (tk && pwrite && ix == FLC_IDX_CLKDIV);
endmodule : flc_regs_props
bind flc_regs flc_regs_props u_props (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .flash_timing_clock(flash_timing_clock), .security_state(security_state));
`default_nettype wire

// ### tb/tb_flash_ctrl_register_map_clock_divider.sv
`timescale 1ns/1ps
`default_nettype none
module tb_flash_ctrl_register_map_clock_divider;
  import flc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic cc = 1'b1;
  logic ce = 1'b1;
  logic [3:0] pstrb = 4'h1;
  logic nv_valid = 1'b1;
  logic nv_dbl = 1'b0;
  logic tick;
  logic [7:0] sec_o;
  logic [2:0] cwi;
  logic [2:0] eri;
  logic [7:0] cfg_o;
  logic [7:0] ecf_o;
  logic [7:0] pp_o;
  logic [7:0] dp_o;
  logic [15:0] cob_o;
  logic [31:0] r;
  logic e;
  logic [4:0] rsv [5] = '{5'h0c, 5'h0d, 5'h11, 5'h12, 5'h13};
  int fail_count = 0;
  int n_checks = 0;
  int i;
  always #5 pclk = ~pclk;
  flc_regs dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .command_complete_flag(cc), .cmd_flags_in(6'h3f), .ecc_fault_flags_in(2'h3), .ecc_result_in(16'h1234),
    .nv_valid(nv_valid), .nv_sec_byte(8'h5a), .nv_opt_byte(8'h3c), .nv_dbl_fault(nv_dbl),
    .flash_timing_clock(tick), .security_state(sec_o), .command_word_index(cwi), .ecc_result_index(eri),
    .controller_config(cfg_o), .error_interrupt_config(ecf_o), .program_array_protection(pp_o),
    .data_array_protection(dp_o), .command_object(cob_o));
  task report_and_stop;
    if (fail_count == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  task cut;
    fail_count++;
    report_and_stop;
  endtask : cut
  task chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x)
    begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
      fail_count++;
    end
  endtask : chk
  // one apb transfer; request held until pready is sampled high
  task apb(input logic w, input logic [4:0] ix, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {1'b0, ix, 2'b00};
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    psel <= 1'b0;
    penable <= 1'b0;
    r = prdata;
    e = pslverr;
    if (n >= 20)
      cut;
  endtask : apb
  task rdc(input logic [4:0] ix, input logic [7:0] x);
    apb(1'b0, ix, 8'h00);
    chk(r, {24'h00_0000, x});
  endtask : rdc
  task gap(output int c);
    c = 0;
    do
    begin
      @(posedge pclk);
      c++;
    end
    while (tick !== 1'b1 && c < 300);
    if (c >= 300)
      cut;
  endtask : gap
  task rst(input logic dbl);
    presetn <= 1'b0;
    nv_dbl <= dbl;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
  endtask : rst
  initial
  begin
    rst(1'b0);
    rdc(FLC_IDX_SEC, 8'h5a);
    chk({24'h00_0000, sec_o}, 32'h0000_005a);
    rdc(FLC_IDX_CLKDIV, 8'h00);
    apb(1'b1, FLC_IDX_SEC, 8'h00);
    rdc(FLC_IDX_SEC, 8'h5a);
    cc <= 1'b0;
    // 0x2f is the band value for the top oscillator range
    apb(1'b1, FLC_IDX_CLKDIV, 8'h2f);
    rdc(FLC_IDX_CLKDIV, 8'haf);
    cc <= 1'b1;
    apb(1'b1, FLC_IDX_CLKDIV, 8'h7f);
    rdc(FLC_IDX_CLKDIV, 8'haf);
    gap(i);
    gap(i);
    chk(32'(i), 32'h0000_0030);
    rdc(FLC_IDX_STAT, 8'hbf);
    rdc(FLC_IDX_ERRSTAT, 8'h03);
    rdc(FLC_IDX_ECCHI, 8'h12);
    rdc(FLC_IDX_ECCLO, 8'h34);
    apb(1'b1, FLC_IDX_CMDIX, 8'hff);
    rdc(FLC_IDX_CMDIX, 8'h07);
    apb(1'b1, FLC_IDX_ECCIX, 8'hff);
    rdc(FLC_IDX_ECCIX, 8'h07);
    apb(1'b1, FLC_IDX_CFG, 8'hff);
    rdc(FLC_IDX_CFG, 8'h93);
    apb(1'b1, FLC_IDX_ERRCFG, 8'hff);
    rdc(FLC_IDX_ERRCFG, 8'h03);
    apb(1'b1, FLC_IDX_PPROT, 8'hff);
    rdc(FLC_IDX_PPROT, 8'hff);
    apb(1'b1, FLC_IDX_DPROT, 8'hff);
    rdc(FLC_IDX_DPROT, 8'h9f);
    chk({10'h000, cwi, eri, cfg_o, ecf_o}, 32'h003f_9303);
    chk({16'h0000, pp_o, dp_o}, 32'h0000_ff9f);
    apb(1'b1, FLC_IDX_COBHI, 8'ha5);
    rdc(FLC_IDX_COBHI, 8'ha5);
    // a write with the low byte lane off must not land
    pstrb <= 4'h0;
    apb(1'b1, FLC_IDX_COBHI, 8'h11);
    pstrb <= 4'h1;
    rdc(FLC_IDX_COBHI, 8'ha5);
    // low half written while the clock enable freezes everything for a while
    fork
      apb(1'b1, FLC_IDX_COBLO, 8'h5c);
      begin
        ce <= 1'b0;
        repeat (6) @(posedge pclk);
        ce <= 1'b1;
      end
    join
    chk({16'h0000, cob_o}, 32'h0000_a55c);
    rdc(FLC_IDX_OPT, 8'h3c);
    for (i = 0; i < 5; i++)
    begin
      apb(1'b1, rsv[i], 8'hff);
      rdc(rsv[i], 8'h00);
    end
    apb(1'b0, 5'h14, 8'h00);
    chk({31'h0000_0000, e}, 32'h0000_0001);
    rst(1'b1);
    rdc(FLC_IDX_SEC, 8'hff);
    rdc(FLC_IDX_CLKDIV, 8'h00);
    report_and_stop;
  end
endmodule : tb_flash_ctrl_register_map_clock_divider
`default_nettype wire
